// ==== usart_cfg_pkg.sv ====
// Function
// - Transmitter sends one stop bit when stop select is 0, two when 1.
// - Receiver frame handling ignores the stop select setting entirely.
// - Width code 000-011 gives 5-8 data bits, 111 gives 9; others reserved.
// - Sync polarity 0: transmit changes on rising, receive samples on falling; 1 swaps.
// - Divisor is 12 bits: top four in high byte, low eight in low byte.
// - Low byte write reloads the prescaler with the new divisor one clock after the divisor register takes it.
// - Divisor zero gives the fastest rate: clock over 16 or over 8 in async, clock over 2 in sync.
// - Double speed cuts the async factor from 16 to 8; ignored, not cleared, in sync.
//
// Constants, register map and carrier types of the frame and rate configuration block.
// Assumes a single system clock and a plain register port with 8-bit data.
package usart_cfg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W = 12;
  localparam int OS_W = 4;
  localparam int BITS_W = 4;
  localparam int FRAME_W = 4;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_FRAME_FORMAT = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_LINE_MODE = 3'h3;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STOP_SEL_BIT = 3;
  localparam int WIDTH_LOW_MSB = 2;
  localparam int WIDTH_LOW_LSB = 1;
  localparam int POLARITY_BIT = 0;
  localparam int SYNC_MODE_BIT = 0;
  localparam int DOUBLE_SPEED_BIT = 1;
  localparam int WIDTH_TOP_BIT = 2;
  localparam int DIV_HIGH_USED = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] FRAME_FORMAT_RST = 8'h06;
  localparam logic [DATA_W-1:0] LINE_MODE_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIVISOR_RST = 12'h000;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Rate factors and frame sizes
  // ----------------------------------------------------------------
  localparam logic [OS_W-1:0] OS_LAST_NORMAL = 4'hf;
  localparam logic [OS_W-1:0] OS_LAST_DOUBLE = 4'h7;
  localparam logic [BITS_W-1:0] BITS_5 = 4'h5;
  localparam logic [BITS_W-1:0] BITS_6 = 4'h6;
  localparam logic [BITS_W-1:0] BITS_7 = 4'h7;
  localparam logic [BITS_W-1:0] BITS_8 = 4'h8;
  localparam logic [BITS_W-1:0] BITS_9 = 4'h9;
  localparam logic [1:0] STOP_ONE = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [FRAME_W-1:0] START_BITS = 4'h1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] width_code;
    logic stop_count_select;
    logic sync_clock_polarity;
    logic double_speed_select;
    logic sync_mode;
  } line_cfg_t;

  typedef struct packed {
    logic tx_shift;
    logic rx_sample;
    logic bit_tick;
  } rate_evt_t;

  // ----------------------------------------------------------------
  // Width code decode
  // ----------------------------------------------------------------
  function automatic logic [BITS_W-1:0] char_bits(input logic [2:0] code);
    logic [BITS_W-1:0] bits;
    unique case (code)
      3'h0: bits = BITS_5;
      3'h1: bits = BITS_6;
      3'h2: bits = BITS_7;
      3'h3: bits = BITS_8;
      3'h7: bits = BITS_9;
      default: bits = BITS_8;
    endcase
    return bits;
  endfunction : char_bits

  function automatic logic width_reserved(input logic [2:0] code);
    return code[2] && (code != 3'h7);
  endfunction : width_reserved

endpackage : usart_cfg_pkg

// ==== baud_prescaler.sv ====
// Down-counting baud prescaler giving one tick every divisor plus one clocks.
// Assumes reload is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
module baud_prescaler
  import usart_cfg_pkg::*;
#(
  parameter int W = DIV_W
)
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic reload,
  input wire logic [W-1:0] divisor,
  output logic tick
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic tick_q;
  logic tick_d;

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  always_comb
  begin
    count_d = count_q - 1'b1;
    tick_d = 1'b0;
    if (reload)
    begin
      count_d = divisor;
    end
    else if (count_q == '0)
    begin
      count_d = divisor;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : baud_prescaler

// ==== usart_frame_format_and_baud_config.sv ====
// Frame format registers, baud divisor registers and rate event generation.
// Assumes one system clock, a plain register port and shift engines outside.
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module usart_frame_format_and_baud_config
  import usart_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output line_cfg_t line_cfg,
  output logic [BITS_W-1:0] data_bits,
  output logic [1:0] tx_stop_bits,
  output logic [FRAME_W-1:0] tx_frame_bits,
  output logic [FRAME_W-1:0] rx_frame_bits,
  output logic width_code_reserved,
  output rate_evt_t rate_evt,
  output logic sync_clock_pin
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_format;
    logic div_high;
    logic div_low;
    logic line_mode;
  } reg_sel_t;

  function automatic reg_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel.frame_format = (addr == OFS_FRAME_FORMAT);
    sel.div_high = (addr == OFS_DIV_HIGH);
    sel.div_low = (addr == OFS_DIV_LOW);
    sel.line_mode = (addr == OFS_LINE_MODE);
    return sel;
  endfunction : reg_decode

  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic [DATA_W-1:0] frame_format_control_q;
  logic [DATA_W-1:0] frame_format_control_d;
  logic [DATA_W-1:0] line_mode_q;
  logic [DATA_W-1:0] line_mode_d;
  logic [DIV_W-1:0] baud_divisor_q;
  logic [DIV_W-1:0] baud_divisor_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic reload_q;
  logic reload_d;

  always_comb
  begin
    wr_sel = reg_wr ? reg_decode(reg_addr) : '0;
    rd_sel = reg_rd ? reg_decode(reg_addr) : '0;
  end

  // ----------------------------------------------------------------
  // Frame format and line mode registers
  // ----------------------------------------------------------------
  always_comb
  begin
    frame_format_control_d = frame_format_control_q;
    line_mode_d = line_mode_q;
    if (wr_sel.frame_format)
    begin
      frame_format_control_d = reg_wdata;
    end
    if (wr_sel.line_mode)
    begin
      line_mode_d = reg_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      frame_format_control_q <= FRAME_FORMAT_RST;
      line_mode_q <= LINE_MODE_RST;
    end
    else
    begin
      frame_format_control_q <= frame_format_control_d;
      line_mode_q <= line_mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Baud divisor registers
  // ----------------------------------------------------------------
  always_comb
  begin
    baud_divisor_d = baud_divisor_q;
    reload_d = 1'b0;
    if (wr_sel.div_high)
    begin
      // Upper nibble is not stored
      baud_divisor_d[DIV_W-1:DATA_W] = reg_wdata[DIV_HIGH_USED-1:0];
    end
    if (wr_sel.div_low)
    begin
      baud_divisor_d[DATA_W-1:0] = reg_wdata;
      reload_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      baud_divisor_q <= DIVISOR_RST;
      reload_q <= 1'b0;
    end
    else
    begin
      baud_divisor_q <= baud_divisor_d;
      reload_q <= reload_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_d = READ_ZERO;
    if (rd_sel.frame_format)
    begin
      rdata_d = frame_format_control_q;
    end
    if (rd_sel.line_mode)
    begin
      rdata_d = line_mode_q;
    end
    if (rd_sel.div_high)
    begin
      rdata_d = {{(DATA_W-DIV_HIGH_USED){1'b0}}, baud_divisor_q[DIV_W-1:DATA_W]};
    end
    if (rd_sel.div_low)
    begin
      rdata_d = baud_divisor_q[DATA_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_q <= READ_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  line_cfg_t cfg_now;
  line_cfg_t cfg_q;
  logic [BITS_W-1:0] data_bits_q;
  logic [BITS_W-1:0] data_bits_d;
  logic [1:0] stop_q;
  logic [1:0] stop_d;
  logic [FRAME_W-1:0] tx_frame_q;
  logic [FRAME_W-1:0] tx_frame_d;
  logic [FRAME_W-1:0] rx_frame_q;
  logic [FRAME_W-1:0] rx_frame_d;
  logic reserved_q;
  logic reserved_d;

  always_comb
  begin
    cfg_now.width_code = {line_mode_q[WIDTH_TOP_BIT],
                          frame_format_control_q[WIDTH_LOW_MSB:WIDTH_LOW_LSB]};
    cfg_now.stop_count_select = frame_format_control_q[STOP_SEL_BIT];
    cfg_now.sync_clock_polarity = frame_format_control_q[POLARITY_BIT];
    cfg_now.double_speed_select = line_mode_q[DOUBLE_SPEED_BIT];
    cfg_now.sync_mode = line_mode_q[SYNC_MODE_BIT];
    data_bits_d = char_bits(cfg_now.width_code);
    reserved_d = width_reserved(cfg_now.width_code);
    stop_d = cfg_now.stop_count_select ? STOP_TWO : STOP_ONE;
    tx_frame_d = FRAME_W'(START_BITS + data_bits_d + FRAME_W'(stop_d));
    // Receiver checks only the first stop bit
    rx_frame_d = FRAME_W'(START_BITS + data_bits_d + FRAME_W'(STOP_ONE));
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= '0;
      data_bits_q <= BITS_8;
      stop_q <= STOP_ONE;
      tx_frame_q <= '0;
      rx_frame_q <= '0;
      reserved_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_now;
      data_bits_q <= data_bits_d;
      stop_q <= stop_d;
      tx_frame_q <= tx_frame_d;
      rx_frame_q <= rx_frame_d;
      reserved_q <= reserved_d;
    end
  end

  assign line_cfg = cfg_q;
  assign data_bits = data_bits_q;
  assign tx_stop_bits = stop_q;
  assign tx_frame_bits = tx_frame_q;
  assign rx_frame_bits = rx_frame_q;
  assign width_code_reserved = reserved_q;

  // ----------------------------------------------------------------
  // Rate generation
  // ----------------------------------------------------------------
  logic presc_tick;

  baud_prescaler #(
    .W(DIV_W)
  ) u_prescaler (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reload(reload_q),
    .divisor(baud_divisor_q),
    .tick(presc_tick)
  );

  logic [OS_W-1:0] os_cnt_q;
  logic [OS_W-1:0] os_cnt_d;
  logic xck_q;
  logic xck_d;
  rate_evt_t evt_q;
  rate_evt_t evt_d;
  logic [OS_W-1:0] os_last;
  logic rise;
  logic fall;

  always_comb
  begin
    os_cnt_d = os_cnt_q;
    xck_d = xck_q;
    evt_d = '0;
    rise = 1'b0;
    fall = 1'b0;
    os_last = cfg_now.double_speed_select ? OS_LAST_DOUBLE : OS_LAST_NORMAL;
    if (reload_q)
    begin
      os_cnt_d = '0;
    end
    else if (presc_tick)
    begin
      if (cfg_now.sync_mode)
      begin
        // Sync clock toggles once per prescaler period
        xck_d = ~xck_q;
        rise = ~xck_q;
        fall = xck_q;
        evt_d.bit_tick = rise;
        evt_d.tx_shift = cfg_now.sync_clock_polarity ? fall : rise;
        evt_d.rx_sample = cfg_now.sync_clock_polarity ? rise : fall;
      end
      else
      begin
        // Receiver oversamples every prescaler tick
        evt_d.rx_sample = 1'b1;
        if (os_cnt_q >= os_last)
        begin
          os_cnt_d = '0;
          evt_d.bit_tick = 1'b1;
          evt_d.tx_shift = 1'b1;
        end
        else
        begin
          os_cnt_d = os_cnt_q + 1'b1;
        end
      end
    end
    if (!cfg_now.sync_mode)
    begin
      xck_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      os_cnt_q <= '0;
      xck_q <= 1'b0;
      evt_q <= '0;
    end
    else
    begin
      os_cnt_q <= os_cnt_d;
      xck_q <= xck_d;
      evt_q <= evt_d;
    end
  end

  assign rate_evt = evt_q;
  assign sync_clock_pin = xck_q;

endmodule : usart_frame_format_and_baud_config

// ==== usart_cfg_asserts.sv ====
// Checker of read timing, frame sizes and rate event relations.
// Assumes it is bound onto the frame and rate configuration top.
`timescale 1ns/1ps
module usart_cfg_asserts
  import usart_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire line_cfg_t line_cfg,
  input wire logic [BITS_W-1:0] data_bits,
  input wire logic [1:0] tx_stop_bits,
  input wire logic [FRAME_W-1:0] tx_frame_bits,
  input wire logic [FRAME_W-1:0] rx_frame_bits,
  input wire logic width_code_reserved,
  input wire rate_evt_t rate_evt,
  input wire logic sync_clock_pin
);
  // ----------------------------------------
  // Settled configuration tracking
  // ----------------------------------------
  logic [1:0] st_q;
  logic [1:0] st_d;
  line_cfg_t cfg_q;
  logic st;
  logic [2:0] wc;
  assign st = (st_q == 2'h3);
  assign wc = line_cfg.width_code;
  always_comb
  begin
    st_d = (line_cfg != cfg_q) ? 2'h0 : ((st_q == 2'h3) ? st_q : st_q + 2'h1);
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= 2'h0;
      cfg_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cfg_q <= line_cfg;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_stop; st |-> tx_stop_bits == (line_cfg.stop_count_select ? STOP_TWO : STOP_ONE); endproperty
  a_stop: assert property (p_stop) else $error("stop count wrong");
  property p_txf; st |-> tx_frame_bits == START_BITS + data_bits + tx_stop_bits; endproperty
  a_txf: assert property (p_txf) else $error("tx frame size wrong");
  property p_rxf; st |-> rx_frame_bits == START_BITS + data_bits + 4'h1; endproperty
  a_rxf: assert property (p_rxf) else $error("rx frame size wrong");
  property p_width; st |-> data_bits == (wc[2] ? (wc == 3'h7 ? BITS_9 : BITS_8) : BITS_5 + wc[1:0]); endproperty
  a_width: assert property (p_width) else $error("data width wrong");
  property p_resv; st |-> width_code_reserved == (wc[2] && wc != 3'h7); endproperty
  a_resv: assert property (p_resv) else $error("reserved flag wrong");
  property p_pol0; st && line_cfg.sync_mode && !line_cfg.sync_clock_polarity |-> rate_evt.tx_shift == rate_evt.bit_tick; endproperty
  a_pol0: assert property (p_pol0) else $error("tx edge wrong");
  property p_pol1; st && line_cfg.sync_mode && line_cfg.sync_clock_polarity |-> rate_evt.rx_sample == rate_evt.bit_tick; endproperty
  a_pol1: assert property (p_pol1) else $error("rx edge wrong");
  property p_apin; st && !line_cfg.sync_mode |-> !sync_clock_pin; endproperty
  a_apin: assert property (p_apin) else $error("clock pin moves in async");
  property p_atx; st && !line_cfg.sync_mode && rate_evt.tx_shift |-> rate_evt.bit_tick; endproperty
  a_atx: assert property (p_atx) else $error("tx shift off bit tick");
  property p_rdz; !$past(reg_rd) |-> reg_rdata == READ_ZERO; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_hi; reg_rd && (reg_addr == OFS_DIV_HIGH || reg_addr[2]) |=> reg_rdata[7:4] == 4'h0; endproperty
  a_hi: assert property (p_hi) else $error("unused bits read nonzero");
  c_sync: cover property (line_cfg.sync_mode && rate_evt.tx_shift);
  c_resv: cover property (width_code_reserved);
  c_dbl: cover property (line_cfg.double_speed_select && rate_evt.bit_tick);
endmodule : usart_cfg_asserts
bind usart_frame_format_and_baud_config usart_cfg_asserts u_chk (.clk_sys, .rstn, .reg_addr,
  .reg_rd, .reg_rdata, .line_cfg, .data_bits, .tx_stop_bits, .tx_frame_bits, .rx_frame_bits,
  .width_code_reserved, .rate_evt, .sync_clock_pin);

// ==== serial_peer_model.sv ====
// Remote synchronous peer counting its own sampling edges.
// Assumes the device drives the clock line.
`timescale 1ns/1ps
module serial_peer_model
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic sync_clock_pin,
  input wire logic sync_clock_polarity,
  output logic [7:0] sample_cnt
);
  logic pin_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_q <= 1'b0;
      sample_cnt <= 8'h00;
    end
    else
    begin
      pin_q <= sync_clock_pin;
      if (pin_q != sync_clock_pin && sync_clock_pin == sync_clock_polarity)
        sample_cnt <= sample_cnt + 8'h01;
    end
  end
endmodule : serial_peer_model

// ==== testbench.sv ====
// Self-checking bench of the frame and rate configuration block.
// Assumes the checker is bound and the peer model is compiled.
`timescale 1ns/1ps
module testbench
  import usart_cfg_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  line_cfg_t line_cfg;
  logic [BITS_W-1:0] data_bits;
  logic [1:0] tx_stop_bits;
  logic [FRAME_W-1:0] tx_frame_bits;
  logic [FRAME_W-1:0] rx_frame_bits;
  logic width_code_reserved;
  rate_evt_t rate_evt;
  logic sync_clock_pin;
  logic [7:0] sample_cnt;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  usart_frame_format_and_baud_config u_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .line_cfg, .data_bits, .tx_stop_bits, .tx_frame_bits, .rx_frame_bits,
    .width_code_reserved, .rate_evt, .sync_clock_pin);
  serial_peer_model u_peer (.clk_sys, .rstn, .sync_clock_pin,
    .sync_clock_polarity(line_cfg.sync_clock_polarity), .sample_cnt);
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic gap(input int i, output int n);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    while (rate_evt[i] !== 1'b1 && n < 999);
  endtask : gap
  task automatic run(input logic [7:0] d, input logic [2:0] m, input logic p, input int i,
    input int e);
    int n;
    wr(OFS_LINE_MODE, {5'h00, m});
    wr(OFS_FRAME_FORMAT, {7'h03, p});
    wr(OFS_DIV_LOW, d); // Rate set while idle
    gap(i, n);
    gap(i, n);
    chk(n, e);
    chk(line_cfg, {3'h3, 1'b0, p, m[1:0]});
  endtask : run
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk(line_cfg, 7'h30);
    chk(tx_frame_bits, 4'ha);
    chk(rx_frame_bits, 4'ha);
    rd(OFS_FRAME_FORMAT, FRAME_FORMAT_RST);
    rd(OFS_LINE_MODE, LINE_MODE_RST);
    rd(OFS_DIV_HIGH, 8'h00);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_width;
    int b;
    for (int c = 0; c < 8; c++)
      for (int s = 0; s < 2; s++)
      begin
        b = (c < 4) ? 5 + c : ((c == 7) ? 9 : 8);
        wr(OFS_FRAME_FORMAT, {4'h5, s[0], c[1:0], 1'b0});
        wr(OFS_LINE_MODE, {5'h00, c[2], 2'h0});
        repeat (3) @(posedge clk_sys);
        #1 chk(data_bits, b);
        chk(width_code_reserved, c[2] && c != 7);
        chk(tx_stop_bits, s + 1);
        chk(tx_frame_bits, b + s + 2);
        chk(rx_frame_bits, b + 2);
        rd(OFS_FRAME_FORMAT, {4'h5, s[0], c[1:0], 1'b0});
      end
    $display("t_width done");
  endtask : t_width
  task automatic t_div;
    int n;
    wr(OFS_DIV_HIGH, 8'hf2);
    rd(OFS_DIV_HIGH, 8'h02);
    wr(OFS_DIV_LOW, 8'h00);
    rd(OFS_DIV_LOW, 8'h00);
    for (int a = 4; a < 8; a++)
    begin
      wr(a[2:0], 8'hff);
      rd(a[2:0], 8'h00);
    end
    wr(OFS_DIV_HIGH, 8'h00);
    wr(OFS_DIV_LOW, 8'h03);
    gap(1, n);
    chk(n < 7, 1'b1);
    $display("t_div done");
  endtask : t_div
  task automatic t_rate;
    logic [7:0] s0;
    run(8'h00, 3'h0, 1'b0, 2, 16);
    run(8'h00, 3'h2, 1'b0, 2, 8);
    run(8'h02, 3'h0, 1'b0, 1, 3);
    run(8'h02, 3'h0, 1'b0, 2, 48);
    run(8'h02, 3'h2, 1'b0, 0, 24);
    run(8'h02, 3'h1, 1'b0, 2, 6);
    run(8'h02, 3'h1, 1'b1, 1, 6);
    s0 = sample_cnt;
    repeat (24) @(posedge clk_sys);
    #1 chk(8'(sample_cnt - s0), 8'h04);
    $display("t_rate done");
  endtask : t_rate
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 t_reset;
    t_width;
    t_div;
    t_rate;
    end_sim;
  end
endmodule : testbench
